// >>> rtl/master_mode_interrupt_prioritizer.sv
// Master-mode interrupt prioritizer with Avalon-MM register slave.
// Assumes timer and DMA events are one-cycle pulses on core_clk,
// external pins are asynchronous, and the core acks with a pulse.
//
// Behaviour
// - Every source has level zero through seven.
// - Reset levels timer0 dma_channel_one 2 pins 3-6.
// - Timers share level; timer0 beats 1 beats 2.
// - Each source level programmable, may be shared.
// - Equal levels broken by fixed source order.
// - Threshold blocks less urgent sources, resets seven.
// - First detected event sets pending request bit.
// - Request only unmasked, permitted, unserviced, urgent enough.
// - Acknowledge returns type of current most urgent.
// - Acknowledge clears pending, sets in-service bit.
// - In-service source not serviced again until cleared.
// - No preemption of a more urgent in-service.
// - Timer event sets status bit and shared request.
// - Shared ack serves first timer; request stays if others.
// - Each timer delivers its own type.
// - Timer in service holds other timers pending.
// - External pin zero returns type twelve.
// - Rising edge on a pin sets pending.
// - Mask bit per source disables it independently.
// - Types fixed: 8,18,19,10,11,12 to 15.
`timescale 1ns/1ps
module master_mode_interrupt_prioritizer (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Interrupt sources
   input wire logic [2:0] timer_evt,
   input wire logic dma_channel_zero,
   input wire logic dma_channel_one,
   input wire logic ext_irq_pin_zero,
   input wire logic ext_irq_pin_one,
   input wire logic ext_irq_pin_two,
   input wire logic ext_irq_pin_three,
   // Processor core
   input wire logic irq_ack,
   output logic irq_req,
   output logic [7:0] irq_type,
   output logic irq_type_valid,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [20:0] levels;
   logic [6:0] mask;
   logic [2:0] threshold;
   logic [6:0] pending;
   logic [6:1] pend_hi;
   logic [6:0] in_service;
   logic [2:0] timer_status;
   logic [3:0] ext_rise;
   logic [6:0] set_req;
   logic [6:0] clr_req;
   logic [6:0] set_isr;
   logic [6:0] clr_isr;
   logic [2:0] tmr_clear;
   logic [2:0] tmr_pick;
   logic [7:0] next_type;
   logic take_ack;
   logic bus_req;
   logic wr_go;
   logic [7:0] reg_ofs;
   logic [31:0] next_readdata;
   logic [2:0] eos_idx;
   logic eos_go;
   logic [6:0] request_view;

   icu_arb_if arb ();

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   ext_pin_sync #(
      .WIDTH(icu_pkg::NUM_EXT)
   ) u_pins (
      .core_clk(core_clk),
      .reset(reset),
      .pin({ext_irq_pin_three, ext_irq_pin_two, ext_irq_pin_one,
            ext_irq_pin_zero}),
      .rise(ext_rise)
   );

   icu_resolver u_resolver (
      .arb(arb)
   );

   // Resolver inputs
   assign arb.pending = pending;
   assign arb.mask = mask;
   assign arb.in_service = in_service;
   assign arb.levels = levels;
   assign arb.threshold = threshold;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Word-aligned offset and request strobes
   assign reg_ofs = {avs_address[7:2], 2'b00};
   assign bus_req = (avs_read || avs_write) && avs_waitrequest;
   assign wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign eos_go = wr_go && reg_ofs == icu_pkg::OFS_EOS;
   assign eos_idx = avs_writedata[2:0];

   // One wait state per access
   always_ff @(posedge core_clk) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !bus_req;
      end
   end

   // Level and mask storage, mask shared with control words
   always_ff @(posedge core_clk) begin
      if (reset) begin
         levels <= icu_pkg::DEF_LEVELS;
         mask <= icu_pkg::DEF_MASK;
         threshold <= icu_pkg::DEF_THRESHOLD;
      end else if (wr_go) begin
         for (int i = 0; i < icu_pkg::NUM_SRC; i++) begin
            if (reg_ofs == icu_pkg::OFS_CTRL0 + 8'(4*i)) begin
               levels[3*i +: 3] <= avs_writedata[2:0];
               mask[i] <= avs_writedata[icu_pkg::CTRL_MASK_BIT];
            end
         end
         if (reg_ofs == icu_pkg::OFS_MASK) begin
            mask <= avs_writedata[6:0];
         end
         if (reg_ofs == icu_pkg::OFS_THRESH) begin
            threshold <= avs_writedata[2:0];
         end
      end
   end

   // Read mux
   assign request_view = {pending[6:1], |timer_status};
   always_comb begin
      next_readdata = 32'h0000_0000;
      for (int i = 0; i < icu_pkg::NUM_SRC; i++) begin
         if (reg_ofs == icu_pkg::OFS_CTRL0 + 8'(4*i)) begin
            next_readdata = {28'h000_0000, mask[i], levels[3*i +: 3]};
         end
      end
      case (reg_ofs)
         icu_pkg::OFS_MASK: next_readdata = {25'h000_0000, mask};
         icu_pkg::OFS_THRESH: next_readdata = {29'h0000_0000, threshold};
         icu_pkg::OFS_REQUEST: next_readdata = {25'h000_0000, request_view};
         icu_pkg::OFS_INSERV: next_readdata = {25'h000_0000, in_service};
         icu_pkg::OFS_TSTAT: next_readdata = {29'h0000_0000, timer_status};
         default: ;
      endcase
   end

   // Read data held for the accepting edge
   always_ff @(posedge core_clk) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (bus_req && avs_read) begin
         avs_readdata <= next_readdata;
      end
   end

   // ----------------------------------------------------------------
   // Acknowledge handling
   // ----------------------------------------------------------------
   assign take_ack = irq_ack && arb.win_valid;

   // First pending timer at the moment of acknowledge
   always_comb begin
      tmr_pick = 3'b000;
      if (timer_status[0]) begin
         tmr_pick = 3'b001;
      end else if (timer_status[1]) begin
         tmr_pick = 3'b010;
      end else if (timer_status[2]) begin
         tmr_pick = 3'b100;
      end
   end

   // Fixed type of the winner
   always_comb begin
      next_type = icu_pkg::TYPE_SPURIOUS;
      if (arb.win_valid) begin
         case (arb.win_idx)
            icu_pkg::SRC_TMR: begin
               if (tmr_pick[0]) next_type = icu_pkg::TYPE_TMR0;
               else if (tmr_pick[1]) next_type = icu_pkg::TYPE_TMR1;
               else next_type = icu_pkg::TYPE_TMR2;
            end
            icu_pkg::SRC_DMA_CHANNEL_ZERO: next_type = icu_pkg::TYPE_DMA_CHANNEL_ZERO;
            icu_pkg::SRC_DMA_CHANNEL_ONE: next_type = icu_pkg::TYPE_DMA_CHANNEL_ONE;
            default: begin
               next_type = icu_pkg::TYPE_EXT0 +
                  8'(arb.win_idx - icu_pkg::SRC_EXT0);
            end
         endcase
      end
   end

   // Set and clear terms
   always_comb begin
      set_req = {ext_rise, dma_channel_one, dma_channel_zero, 1'b0};
      clr_req = 7'h00;
      set_isr = 7'h00;
      clr_isr = 7'h00;
      tmr_clear = 3'b000;
      if (take_ack) begin
         clr_req[arb.win_idx] = 1'b1;
         set_isr[arb.win_idx] = 1'b1;
         if (arb.win_idx == icu_pkg::SRC_TMR) begin
            tmr_clear = tmr_pick;
         end
      end
      if (eos_go && eos_idx < 3'(icu_pkg::NUM_SRC)) begin
         clr_isr[eos_idx] = 1'b1;
      end
   end

   // Pending requests, set beats clear
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pend_hi <= 6'h00;
      end else begin
         pend_hi <= (pend_hi & ~clr_req[6:1]) | set_req[6:1];
      end
   end

   // Second-level timer status, set beats clear
   always_ff @(posedge core_clk) begin
      if (reset) begin
         timer_status <= 3'b000;
      end else begin
         timer_status <= (timer_status & ~tmr_clear) | timer_evt;
      end
   end

   // Shared timer request follows any status bit
   assign pending = {pend_hi, |timer_status};

   // In-service tracking, set beats clear
   always_ff @(posedge core_clk) begin
      if (reset) begin
         in_service <= 7'h00;
      end else begin
         in_service <= (in_service & ~clr_isr) | set_isr;
      end
   end

   // Request and type towards the core
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_req <= 1'b0;
         irq_type <= 8'h00;
         irq_type_valid <= 1'b0;
      end else begin
         irq_req <= arb.win_valid && !irq_ack;
         irq_type_valid <= irq_ack;
         if (irq_ack) begin
            irq_type <= next_type;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [2:0] lvl_win;
   assign lvl_win = levels[3*arb.win_idx +: 3];

   a_reset_levels: assert property (@(posedge core_clk)
      $fell(reset) |-> levels == icu_pkg::DEF_LEVELS
         && threshold == 3'h7)
      else $error("levels not at defaults after reset");

   a_threshold_gate: assert property (@(posedge core_clk)
      disable iff (reset) arb.win_valid |-> lvl_win <= threshold)
      else $error("winner less urgent than threshold");

   a_mask_gate: assert property (@(posedge core_clk)
      disable iff (reset) arb.win_valid |-> !mask[arb.win_idx])
      else $error("masked source won");

   a_no_self_nest: assert property (@(posedge core_clk)
      disable iff (reset) arb.win_valid |-> !in_service[arb.win_idx])
      else $error("in-service source won again");

   a_ack_marks_isr: assert property (@(posedge core_clk)
      disable iff (reset) take_ack |=> in_service[$past(arb.win_idx)])
      else $error("acknowledge did not set in-service");

   a_ext0_type: assert property (@(posedge core_clk)
      disable iff (reset) take_ack && arb.win_idx == icu_pkg::SRC_EXT0
         |=> irq_type_valid && irq_type == 8'h0C)
      else $error("pin zero type wrong");

   a_edge_pending: assert property (@(posedge core_clk)
      disable iff (reset) ext_rise[0] |=> pending[3])
      else $error("rising edge lost");

   a_req_follows: assert property (@(posedge core_clk)
      disable iff (reset) !arb.win_valid |=> !irq_req)
      else $error("request without qualifying source");

   a_timer_keep: assert property (@(posedge core_clk)
      disable iff (reset) take_ack && arb.win_idx == icu_pkg::SRC_TMR
         && timer_status[0] && timer_status[1] |=> pending[0]
         && !timer_status[0])
      else $error("shared timer request dropped early");

   a_bus_answer: assert property (@(posedge core_clk)
      disable iff (reset) bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one wait state");

   // Most urgent in-service level, worked out apart from the resolver
   logic [2:0] isr_top;
   always_comb begin
      isr_top = 3'h7;
      for (int i = 0; i < icu_pkg::NUM_SRC; i++) begin
         if (in_service[i] && levels[3*i +: 3] < isr_top) begin
            isr_top = levels[3*i +: 3];
         end
      end
   end

   a_no_preempt: assert property (@(posedge core_clk)
      disable iff (reset) arb.win_valid |-> lvl_win <= isr_top)
      else $error("winner preempts a more urgent in-service source");

   a_ack_clears_req: assert property (@(posedge core_clk)
      disable iff (reset) take_ack && arb.win_idx != icu_pkg::SRC_TMR
         && !set_req[arb.win_idx] |=> !pending[$past(arb.win_idx)])
      else $error("acknowledge left request pending");

   a_timer_type: assert property (@(posedge core_clk)
      disable iff (reset) take_ack && arb.win_idx == icu_pkg::SRC_TMR
         && tmr_pick[1] |=> irq_type == icu_pkg::TYPE_TMR1)
      else $error("timer one type wrong");

   a_eos_clears: assert property (@(posedge core_clk)
      disable iff (reset) eos_go && eos_idx < 3'h7 && !set_isr[eos_idx]
         |=> !in_service[$past(eos_idx)])
      else $error("end-of-service left bit set");
endmodule // master_mode_interrupt_prioritizer

// >>> rtl/icu_pkg.sv
// Constants shared by the interrupt prioritizer and its helpers.
// Assumes a single core_clk domain and word-aligned Avalon-MM offsets.
package icu_pkg;

   // ----------------------------------------------------------------
   // Source indices
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 7;
   localparam int NUM_TMR = 3;
   localparam int NUM_EXT = 4;
   localparam logic [2:0] SRC_TMR = 3'h0;
   localparam logic [2:0] SRC_DMA_CHANNEL_ZERO = 3'h1;
   localparam logic [2:0] SRC_DMA_CHANNEL_ONE = 3'h2;
   localparam logic [2:0] SRC_EXT0 = 3'h3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [20:0] DEF_LEVELS = {3'h6, 3'h5, 3'h4, 3'h3, 3'h2,
                                         3'h1, 3'h0};
   localparam logic [2:0] DEF_THRESHOLD = 3'h7;
   localparam logic [6:0] DEF_MASK = 7'h00;

   // ----------------------------------------------------------------
   // Fixed interrupt types
   // ----------------------------------------------------------------
   localparam logic [7:0] TYPE_TMR0 = 8'h08;
   localparam logic [7:0] TYPE_TMR1 = 8'h12;
   localparam logic [7:0] TYPE_TMR2 = 8'h13;
   localparam logic [7:0] TYPE_DMA_CHANNEL_ZERO = 8'h0A;
   localparam logic [7:0] TYPE_DMA_CHANNEL_ONE = 8'h0B;
   localparam logic [7:0] TYPE_EXT0 = 8'h0C;
   localparam logic [7:0] TYPE_SPURIOUS = 8'h07;

   // ----------------------------------------------------------------
   // Register byte offsets and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h1C;
   localparam logic [7:0] OFS_THRESH = 8'h20;
   localparam logic [7:0] OFS_REQUEST = 8'h24;
   localparam logic [7:0] OFS_INSERV = 8'h28;
   localparam logic [7:0] OFS_TSTAT = 8'h2C;
   localparam logic [7:0] OFS_EOS = 8'h30;
   localparam int CTRL_MASK_BIT = 3;

endpackage

// >>> rtl/icu_arb_if.sv
// Carrier between the register core and the priority resolver.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface icu_arb_if;
   logic [6:0] pending;
   logic [6:0] mask;
   logic [6:0] in_service;
   logic [20:0] levels;
   logic [2:0] threshold;
   logic win_valid;
   logic [2:0] win_idx;

   modport core (output pending, mask, in_service, levels, threshold,
                 input win_valid, win_idx);
   modport resolver (input pending, mask, in_service, levels, threshold,
                     output win_valid, win_idx);
endinterface

// >>> rtl/ext_pin_sync.sv
// Two-stage synchroniser with rising-edge pulse per pin.
// Assumes pins are asynchronous to core_clk.
`timescale 1ns/1ps
module ext_pin_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Pins in, pulses out
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] rise
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stable;
   logic [WIDTH-1:0] last;

   // Refuse an empty pin group
   if (WIDTH < 1) begin : g_bad_width
      $error("ext_pin_sync: WIDTH must be positive");
   end

   // Synchroniser and edge history
   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta <= '0;
         stable <= '0;
         last <= '0;
      end else begin
         meta <= pin;
         stable <= meta;
         last <= stable;
      end
   end

   // Low-to-high detection on the settled level
   assign rise = stable & ~last;
endmodule // ext_pin_sync

// >>> rtl/icu_resolver.sv
// Picks the most urgent qualifying source.
// Assumes combinational use inside one clock domain.
`timescale 1ns/1ps
module icu_resolver (
   // Arbitration carrier
   icu_arb_if.resolver arb
);
   logic [2:0] lvl [icu_pkg::NUM_SRC];
   logic [2:0] min_isr;
   logic any_isr;
   logic [6:0] qual;
   logic [2:0] best_lvl;

   // Unpack levels
   always_comb begin
      for (int i = 0; i < icu_pkg::NUM_SRC; i++) begin
         lvl[i] = arb.levels[3*i +: 3];
      end
   end

   // Most urgent level in service
   always_comb begin
      min_isr = 3'h7;
      any_isr = 1'b0;
      for (int i = 0; i < icu_pkg::NUM_SRC; i++) begin
         if (arb.in_service[i] && lvl[i] <= min_isr) begin
            min_isr = lvl[i];
            any_isr = 1'b1;
         end
      end
   end

   // Qualification per source
   always_comb begin
      for (int i = 0; i < icu_pkg::NUM_SRC; i++) begin
         qual[i] = arb.pending[i] && !arb.mask[i]
            && lvl[i] <= arb.threshold
            && !arb.in_service[i]
            && (!any_isr || lvl[i] <= min_isr);
      end
   end

   // Lowest level wins, lowest index breaks ties
   always_comb begin
      arb.win_valid = 1'b0;
      arb.win_idx = 3'h0;
      best_lvl = 3'h7;
      for (int i = 0; i < icu_pkg::NUM_SRC; i++) begin
         if (qual[i] && (!arb.win_valid || lvl[i] < best_lvl)) begin
            arb.win_valid = 1'b1;
            arb.win_idx = 3'(i);
            best_lvl = lvl[i];
         end
      end
   end
endmodule // icu_resolver

// >>> tb/core_model.sv
// Processor-side partner: acknowledges the request and takes the type.
// Assumes one core_clk domain and a bench that gates it with enable.
`timescale 1ns/1ps
module core_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Bench control
   input wire logic enable,
   input wire logic slow,
   // Prioritizer side
   input wire logic irq_req,
   input wire logic irq_type_valid,
   input wire logic [7:0] irq_type,
   output logic irq_ack,
   // Observed answers
   output logic [7:0] got_type,
   output int got_cnt
);
   int wait_n;
   logic busy;

   // One ack per request, then wait for the type
   always @(posedge core_clk) begin
      if (reset) begin
         irq_ack <= 1'b0;
         busy <= 1'b0;
         wait_n <= 0;
         got_cnt <= 0;
         got_type <= 8'h00;
      end else if (irq_type_valid) begin
         irq_ack <= 1'b0;
         got_type <= irq_type;
         got_cnt <= got_cnt + 1;
         busy <= 1'b0;
      end else if (!busy && enable && irq_req) begin
         if (wait_n >= (slow ? 3 : 0)) begin
            irq_ack <= 1'b1;
            busy <= 1'b1;
            wait_n <= 0;
         end else begin
            irq_ack <= 1'b0;
            wait_n <= wait_n + 1;
         end
      end else begin
         irq_ack <= 1'b0;
      end
   end
endmodule // core_model

// >>> tb/master_mode_interrupt_prioritizer_test.sv
// Self-checking bench for the interrupt prioritizer against a model.
// Assumes the core_model partner and the Avalon-MM one-wait-state slave.
`timescale 1ns/1ps
module master_mode_interrupt_prioritizer_test;
   // -------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] timer_evt = 3'h0;
   logic [1:0] dma = 2'h0;
   logic [3:0] ext = 4'h0;
   logic irq_ack, irq_req, irq_type_valid, avs_waitrequest;
   logic [7:0] irq_type, got_type;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic en = 1'b0;
   logic slow = 1'b0;
   int got_cnt, miscompares = 0, samples_checked = 0, w;
   int seed = 32'hf42eae35;
   int lvl[7], msk[7], pend[7], insv[7], tst[7], thr;

   always #5 core_clk = ~core_clk;

   master_mode_interrupt_prioritizer dut (.core_clk(core_clk),
      .reset(reset), .timer_evt(timer_evt), .dma_channel_zero(dma[0]),
      .dma_channel_one(dma[1]), .ext_irq_pin_zero(ext[0]),
      .ext_irq_pin_one(ext[1]), .ext_irq_pin_two(ext[2]),
      .ext_irq_pin_three(ext[3]), .irq_ack(irq_ack), .irq_req(irq_req),
      .irq_type(irq_type), .irq_type_valid(irq_type_valid),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   core_model core (.core_clk(core_clk), .reset(reset), .enable(en),
      .slow(slow), .irq_req(irq_req), .irq_type_valid(irq_type_valid),
      .irq_type(irq_type), .irq_ack(irq_ack), .got_type(got_type),
      .got_cnt(got_cnt));

   // -------------------------------------------------------------
   // Reporting
   // -------------------------------------------------------------
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // Bus and event drivers
   // -------------------------------------------------------------
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) check("waitrequest", 32'h1, 32'h0);
   endtask

   task automatic setctl(int i, int l, int m);
      bus(1'b1, 8'(4 * i), 32'(8 * m + l), q);
      lvl[i] = l;
      msk[i] = m;
   endtask

   task automatic pin(int i);
      @(posedge core_clk);
      ext[i] <= 1'b1;
      repeat (5) @(posedge core_clk);
      ext[i] <= 1'b0;
      repeat (5) @(posedge core_clk);
      pend[3 + i] = 1;
   endtask

   // -------------------------------------------------------------
   // Reference model
   // -------------------------------------------------------------
   function automatic int winner();
      int b, ok;
      b = -1;
      for (int i = 0; i < 7; i++) begin
         ok = pend[i] && !msk[i] && lvl[i] <= thr && !insv[i];
         for (int j = 0; j < 7; j++) if (insv[j] && lvl[j] < lvl[i]) ok = 0;
         if (ok && (b < 0 || lvl[i] < lvl[b])) b = i;
      end
      return b;
   endfunction

   function automatic logic [31:0] pk(int a[7], int n);
      logic [31:0] v;
      v = 32'h0;
      for (int i = 0; i < n; i++) v[i] = (a[i] != 0);
      return v;
   endfunction

   task automatic regs_check();
      bus(1'b0, 8'h24, 32'h0, q);
      check("request", q, pk(pend, 7));
      bus(1'b0, 8'h28, 32'h0, q);
      check("in_service", q, pk(insv, 7));
      bus(1'b0, 8'h2C, 32'h0, q);
      check("timer_status", q, pk(tst, 3));
   endtask

   // Ack through the partner and predict the type
   task automatic serve(output int s);
      int n0, n, k, e;
      s = winner();
      n0 = got_cnt;
      n = 0;
      slow <= $random(seed) & 1;
      en <= 1'b1;
      while (got_cnt == n0 && n < 60) begin
         @(posedge core_clk);
         n++;
         // One ack only: a second qualifying source must not be served
         if (irq_ack === 1'b1) en <= 1'b0;
      end
      en <= 1'b0;
      if (n >= 60) check("ack answer", 32'h1, 32'h0);
      if (s == 0) begin
         k = tst[0] ? 0 : (tst[1] ? 1 : 2);
         e = (k == 0) ? 8 : 17 + k;
         tst[k] = 0;
         pend[0] = tst[0] | tst[1] | tst[2];
      end else begin
         e = 9 + s;
         pend[s] = 0;
      end
      insv[s] = 1;
      check("irq_type", got_type, e);
   endtask

   task automatic eos(int i);
      bus(1'b1, 8'h30, 32'(i), q);
      insv[i] = 0;
   endtask

   task automatic idle_check();
      repeat (3) @(posedge core_clk);
      check("irq_req", irq_req, winner() >= 0);
   endtask

   task automatic drain();
      while (winner() >= 0) begin
         serve(w);
         regs_check();
         eos(w);
      end
      idle_check();
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial begin
      for (int i = 0; i < 7; i++) begin
         lvl[i] = i;
         msk[i] = 0;
         pend[i] = 0;
         insv[i] = 0;
         tst[i] = 0;
      end
      thr = 7;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      // Reset values and an unmapped read
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, 8'(4 * i), 32'h0, q);
         check("level", q, 32'(i));
      end
      bus(1'b0, 8'h1C, 32'h0, q);
      check("mask", q, 32'h0);
      bus(1'b0, 8'h20, 32'h0, q);
      check("threshold", q, 32'h7);
      bus(1'b0, 8'h40, 32'h0, q);
      check("unmapped", q, 32'h0);
      $display("test reset done");
      // Later urgent pin wins, then nesting blocks a lower pin
      pin(1);
      pin(0);
      serve(w);
      regs_check();
      pin(3);
      idle_check();
      eos(w);
      drain();
      $display("test pins done");
      // Shared timer input
      @(posedge core_clk);
      timer_evt <= 3'h7;
      @(posedge core_clk);
      timer_evt <= 3'h0;
      repeat (2) @(posedge core_clk);
      tst[0] = 1;
      tst[1] = 1;
      tst[2] = 1;
      pend[0] = 1;
      serve(w);
      regs_check();
      idle_check();
      eos(0);
      drain();
      $display("test timers done");
      // Shared level, then masking through the mask register
      setctl(3, 7, 0);
      setctl(4, 7, 0);
      pin(1);
      pin(0);
      drain();
      bus(1'b1, 8'h1C, 32'h8, q);
      msk[3] = 1;
      pin(0);
      pin(1);
      drain();
      bus(1'b1, 8'h1C, 32'h0, q);
      msk[3] = 0;
      drain();
      $display("test levels done");
      // Random levels and thresholds on the two DMA channels
      for (int r = 0; r < 8; r++) begin
         setctl(1, $random(seed) & 7, 0);
         setctl(2, $random(seed) & 7, 0);
         thr = $random(seed) & 7;
         bus(1'b1, 8'h20, 32'(thr), q);
         @(posedge core_clk);
         dma <= 2'h3;
         @(posedge core_clk);
         dma <= 2'h0;
         repeat (2) @(posedge core_clk);
         pend[1] = 1;
         pend[2] = 1;
         drain();
         thr = 7;
         bus(1'b1, 8'h20, 32'h7, q);
         drain();
      end
      $display("test random done");
      end_sim();
   end

   // Watchdog
   initial begin
      #400000;
      miscompares++;
      end_sim();
   end
endmodule // master_mode_interrupt_prioritizer_test
